/* verilog/psb_regs.vh */
`ifndef PSB_REGS_VH
`define PSB_REGS_VH
`define PSB_MODE_ON 3'h1
`define PSB_MODE_BLOCKED 3'h2
`define PSB_MODE_TEST 3'h3
`define PSB_MODE_TEST_BLOCKED 3'h4
`define PSB_MODE_OFF 3'h5
`define PSB_COND_NORMAL 2'h0
`define PSB_COND_START 2'h1
`define PSB_COND_TRIP 2'h2
`define PSB_COND_BLOCKED 2'h3
`define PSB_CFG_OK 2'h0
`define PSB_CFG_BAD_VT 2'h1
`define PSB_CFG_BAD_CHAR 2'h2
`define PSB_EV_START_ON 3'h0
`define PSB_EV_START_OFF 3'h1
`define PSB_EV_TRIP_ON 3'h2
`define PSB_EV_TRIP_OFF 3'h3
`define PSB_EV_BLOCKED_ON 3'h4
`define PSB_EV_BLOCKED_OFF 3'h5
`define PSB_SEL_ON 2'h0
`define PSB_SEL_OFF 2'h1
`define PSB_SEL_BOTH 2'h2
`define PSB_HIST_DEPTH 12
`define PSB_TS_RES_NS 1000000
`define PSB_CLK_NS 10
`define PSB_TICK_CYC (`PSB_TS_RES_NS / `PSB_CLK_NS)
`define PSB_BLOCK_LEAD_MS 5
`endif

/* verilog/psb_history.v */
`timescale 1ns/1ps
`include "psb_regs.vh"
// Ring of the most recent operation records; index 0 on readout is oldest.
module psb_history #(
  parameter DEPTH = `PSB_HIST_DEPTH,
  parameter RW = 64,
  parameter AW = 4
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire wr_i,
  input wire [RW-1:0] rec_i,
  input wire [AW-1:0] rd_idx_i,
  output reg [RW-1:0] rd_rec_o,
  output reg [AW-1:0] count_o
);
  reg [RW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] oldest;
  reg [AW:0] sum;
  localparam [AW:0] DEPTH_W = DEPTH;

  function [AW-1:0] wrap_inc;
    input [AW-1:0] v;
    begin
      wrap_inc = (v == DEPTH - 1) ? {AW{1'b0}} : v + 1'b1;
    end
  endfunction

  always @* begin
    oldest = (count_o == DEPTH) ? wp_r : {AW{1'b0}};
    sum = {1'b0, oldest} + {1'b0, rd_idx_i};
    if (sum >= DEPTH)
      sum = sum - DEPTH_W;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wp_r <= {AW{1'b0}};
      count_o <= {AW{1'b0}};
      rd_rec_o <= {RW{1'b0}};
    end else begin
      if (wr_i) begin
        mem[wp_r] <= rec_i;
        wp_r <= wrap_inc(wp_r);
        if (count_o != DEPTH)
          count_o <= count_o + 1'b1;
      end
      rd_rec_o <= (rd_idx_i < count_o) ? mem[sum[AW-1:0]] : {RW{1'b0}};
    end
  end
endmodule

/* verilog/psb_logger.v */
`timescale 1ns/1ps
`include "psb_regs.vh"
module psb_logger #(
  parameter TICK_CYC = `PSB_TICK_CYC,
  parameter TW = 32,
  parameter ZW = 16,
  parameter BTW = 16
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire cycle_start_i,
  input wire pickup_i,
  input wire trip_req_i,
  input wire release_done_i,
  input wire block_in_i,
  input wire force_enable_i,
  input wire force_block_sw_i,
  input wire logical_node_mode_allowed_i,
  input wire [2:0] logical_node_mode_i,
  input wire vt_setup_bad_i,
  input wire char_setup_bad_i,
  input wire [1:0] event_sel_i,
  input wire [ZW-1:0] imp_r_i,
  input wire [ZW-1:0] imp_x_i,
  input wire [BTW-1:0] blinder_time_i,
  input wire [2:0] setting_group_used_i,
  input wire [3:0] hist_idx_i,
  output reg start_o,
  output reg trip_o,
  output reg blocked_o,
  output reg [2:0] behaviour_o,
  output reg [1:0] condition_o,
  output reg [1:0] config_status_o,
  output reg display_event_o,
  output reg ev_valid_o,
  output reg [2:0] ev_code_o,
  output reg [TW-1:0] ev_time_o,
  output reg [ZW-1:0] ev_imp_r_o,
  output reg [ZW-1:0] ev_imp_x_o,
  output reg [BTW-1:0] ev_blinder_time_o,
  output wire [TW+BTW+6-1:0] hist_rec_o,
  output wire [3:0] hist_count_o
);
  localparam RW = TW + BTW + 6;
  localparam [31:0] TICK_LAST = TICK_CYC - 1;
  localparam SW = TW + 2 * ZW + BTW + 3;
  localparam BT_LSB = 3;
  localparam ZX_LSB = BTW + 3;
  localparam ZR_LSB = ZW + BTW + 3;
  localparam TS_LSB = 2 * ZW + BTW + 3;

  reg [31:0] tick_r;
  reg [TW-1:0] ms_r;
  reg [2:0] evq_on_r;
  reg [2:0] evq_off_r;
  reg hist_wr_r;
  reg [RW-1:0] hist_data_r;
  reg blk_now;
  reg start_nxt;
  reg trip_nxt;
  reg blocked_nxt;
  reg [2:0] on_ev;
  reg [2:0] off_ev;
  reg [2:0] sel;
  reg sel_on;
  reg [2:0] code;
  integer i;
  integer j;
  // One snapshot slot per event code, frozen at the edge that raises it.
  reg [SW-1:0] snap_r [0:5];
  wire [SW-1:0] snap_now = {ms_r, imp_r_i, imp_x_i, blinder_time_i,
                            setting_group_used_i};
  wire [SW-1:0] snap_out = snap_r[code];

  function [2:0] ev_code;
    input [1:0] idx;
    input is_off;
    begin
      ev_code = {idx[1:0], 1'b0} + {2'b00, is_off};
    end
  endfunction

  function sel_pass;
    input [1:0] mode;
    input is_off;
    begin
      sel_pass = (mode == `PSB_SEL_BOTH) ||
                 (mode == `PSB_SEL_ON && !is_off) ||
                 (mode == `PSB_SEL_OFF && is_off);
    end
  endfunction

  // Blocking source; in forcing mode the software switch replaces the pin.
  always @* begin
    blk_now = force_enable_i ? force_block_sw_i : block_in_i;
    start_nxt = start_o;
    trip_nxt = trip_o;
    blocked_nxt = blocked_o;
    if (cycle_start_i) begin
      // Blocking used this cycle is the freshly sampled value.
      if (pickup_i && !blk_now) begin
        start_nxt = 1'b1;
        blocked_nxt = 1'b0;
      end else if (pickup_i && blk_now) begin
        blocked_nxt = 1'b1;
        start_nxt = 1'b0;
      end else if (release_done_i) begin
        start_nxt = 1'b0;
        blocked_nxt = blk_now & blocked_o;
      end
      if (!pickup_i && !blk_now)
        blocked_nxt = 1'b0;
      trip_nxt = start_nxt & trip_req_i;
    end
    on_ev = {blocked_nxt & ~blocked_o, trip_nxt & ~trip_o,
             start_nxt & ~start_o};
    off_ev = {~blocked_nxt & blocked_o, ~trip_nxt & trip_o,
              ~start_nxt & start_o};
    // One event leaves per clock; ON before OFF, lowest signal first.
    sel = 3'h0;
    sel_on = 1'b0;
    code = 3'h0;
    for (i = 2; i >= 0; i = i - 1) begin
      if (evq_off_r[i]) begin
        sel = 3'h1 << i;
        sel_on = 1'b0;
        code = ev_code(i[1:0], 1'b1);
      end
    end
    for (i = 2; i >= 0; i = i - 1) begin
      if (evq_on_r[i]) begin
        sel = 3'h1 << i;
        sel_on = 1'b1;
        code = ev_code(i[1:0], 1'b0);
      end
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_r <= 32'h0;
      ms_r <= {TW{1'b0}};
      start_o <= 1'b0;
      trip_o <= 1'b0;
      blocked_o <= 1'b0;
      behaviour_o <= 3'h0;
      condition_o <= `PSB_COND_NORMAL;
      config_status_o <= `PSB_CFG_OK;
      display_event_o <= 1'b0;
      ev_valid_o <= 1'b0;
      ev_code_o <= 3'h0;
      ev_time_o <= {TW{1'b0}};
      ev_imp_r_o <= {ZW{1'b0}};
      ev_imp_x_o <= {ZW{1'b0}};
      ev_blinder_time_o <= {BTW{1'b0}};
      evq_on_r <= 3'h0;
      evq_off_r <= 3'h0;
      hist_wr_r <= 1'b0;
      hist_data_r <= {RW{1'b0}};
    end else begin
      if (tick_r == TICK_LAST) begin
        tick_r <= 32'h0;
        ms_r <= ms_r + 1'b1;
      end else begin
        tick_r <= tick_r + 32'h1;
      end
      // Events born on one edge share one stamp even if they leave later.
      for (j = 0; j < 3; j = j + 1) begin
        if (on_ev[j])
          snap_r[2 * j] <= snap_now;
        if (off_ev[j])
          snap_r[2 * j + 1] <= snap_now;
      end
      start_o <= start_nxt;
      trip_o <= trip_nxt;
      blocked_o <= blocked_nxt;
      display_event_o <= blocked_nxt & ~blocked_o;
      // Pending events queue up; a fresh edge wins over the dequeue.
      evq_on_r <= (evq_on_r & ~(sel_on ? sel : 3'h0)) | on_ev;
      evq_off_r <= (evq_off_r & ~(sel_on ? 3'h0 : sel)) | off_ev;
      ev_valid_o <= 1'b0;
      if (sel != 3'h0 && sel_pass(event_sel_i, ~sel_on)) begin
        ev_valid_o <= 1'b1;
        ev_code_o <= code;
        ev_time_o <= snap_out[TS_LSB +: TW];
        ev_imp_r_o <= snap_out[ZR_LSB +: ZW];
        ev_imp_x_o <= snap_out[ZX_LSB +: ZW];
        ev_blinder_time_o <= snap_out[BT_LSB +: BTW];
      end
      hist_wr_r <= 1'b0;
      if (sel != 3'h0 && sel_on) begin
        hist_wr_r <= 1'b1;
        hist_data_r <= {snap_out[TS_LSB +: TW], code, snap_out[2:0],
                        snap_out[BT_LSB +: BTW]};
      end
      behaviour_o <= logical_node_mode_allowed_i ?
                     logical_node_mode_i : 3'h0;
      if (blocked_nxt)
        condition_o <= `PSB_COND_BLOCKED;
      else if (trip_nxt)
        condition_o <= `PSB_COND_TRIP;
      else if (start_nxt)
        condition_o <= `PSB_COND_START;
      else
        condition_o <= `PSB_COND_NORMAL;
      if (vt_setup_bad_i)
        config_status_o <= `PSB_CFG_BAD_VT;
      else if (char_setup_bad_i)
        config_status_o <= `PSB_CFG_BAD_CHAR;
      else
        config_status_o <= `PSB_CFG_OK;
    end
  end

  psb_history #(
    .DEPTH(`PSB_HIST_DEPTH),
    .RW(RW),
    .AW(4)
  ) u_hist (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(hist_wr_r),
    .rec_i(hist_data_r),
    .rd_idx_i(hist_idx_i),
    .rd_rec_o(hist_rec_o),
    .count_o(hist_count_o)
  );
endmodule

/* testbench/psb_logger_assertions.sv */
`timescale 1ns/1ps
`include "psb_regs.vh"
module psb_logger_assertions (
  input logic clk_i,
  input logic sys_rst_i,
  input logic cycle_start_i,
  input logic pickup_i,
  input logic block_in_i,
  input logic force_enable_i,
  input logic force_block_sw_i,
  input logic vt_setup_bad_i,
  input logic [1:0] event_sel_i,
  input logic start_o,
  input logic blocked_o,
  input logic [1:0] condition_o,
  input logic [1:0] config_status_o,
  input logic display_event_o,
  input logic ev_valid_o,
  input logic [2:0] ev_code_o,
  input logic [3:0] hist_count_o
);
  wire blk = force_enable_i ? force_block_sw_i : block_in_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_start_open: assert property (
    cycle_start_i && pickup_i && !blk && !blocked_o |=> start_o)
    else $error("start not raised");
  chk_block_gate: assert property (
    cycle_start_i && pickup_i && blk |=> blocked_o && !start_o)
    else $error("blocking not applied");
  chk_strobe_only: assert property (
    !cycle_start_i |=> $stable(start_o) && $stable(blocked_o))
    else $error("state moved without strobe");
  chk_disp_event: assert property (
    $rose(blocked_o) |-> ##[0:2] display_event_o)
    else $error("no display event");
  chk_cond_blocked: assert property (
    blocked_o |-> condition_o == `PSB_COND_BLOCKED)
    else $error("condition not blocked");
  chk_cfg_code: assert property (
    cycle_start_i && vt_setup_bad_i |=>
    config_status_o == `PSB_CFG_BAD_VT)
    else $error("config code wrong");
  chk_ev_sel: assert property (
    ev_valid_o && event_sel_i != `PSB_SEL_BOTH |->
    ev_code_o[0] == event_sel_i[0])
    else $error("event kind not selected");
  chk_hist_depth: assert property (
    hist_count_o <= 4'hc)
    else $error("history too deep");
  chk_start_event: assert property (
    $rose(start_o) && event_sel_i != `PSB_SEL_OFF |=>
    ev_valid_o && ev_code_o == `PSB_EV_START_ON)
    else $error("start event missing");
endmodule
bind psb_logger psb_logger_assertions chk (.clk_i, .sys_rst_i,
  .cycle_start_i, .pickup_i, .block_in_i, .force_enable_i,
  .force_block_sw_i, .vt_setup_bad_i, .event_sel_i, .start_o,
  .blocked_o, .condition_o, .config_status_o, .display_event_o,
  .ev_valid_o, .ev_code_o, .hist_count_o);

/* testbench/psb_evbuf_model.sv */
`timescale 1ns/1ps
`include "psb_regs.vh"
module psb_evbuf_model (
  input logic clk_i,
  input logic ev_valid_i,
  input logic [2:0] ev_code_i,
  input logic [31:0] ev_time_i,
  input logic [15:0] ev_imp_r_i,
  input logic [15:0] ev_imp_x_i,
  input logic [15:0] ev_bt_i,
  output int on_n_o = 0,
  output int off_n_o = 0,
  output logic [15:0] last_r_o = 16'h0000,
  output logic [15:0] last_x_o = 16'h0000,
  output logic [15:0] last_bt_o = 16'h0000,
  output logic [31:0] start_t_o = 32'h0,
  output logic [31:0] trip_t_o = 32'h0
);
  always @(posedge clk_i) if (ev_valid_i) begin
    if (ev_code_i[0]) off_n_o <= off_n_o + 1;
    else on_n_o <= on_n_o + 1;
    last_r_o <= ev_imp_r_i;
    last_x_o <= ev_imp_x_i;
    last_bt_o <= ev_bt_i;
    if (ev_code_i == `PSB_EV_START_ON) start_t_o <= ev_time_i;
    if (ev_code_i == `PSB_EV_TRIP_ON) trip_t_o <= ev_time_i;
  end
endmodule

/* testbench/psb_logger_tb_top.sv */
`timescale 1ns/1ps
`include "psb_regs.vh"
module psb_logger_tb_top;
  logic clk_i = 0, sys_rst_i = 1, cycle_start_i = 0, pickup_i = 0;
  logic trip_req_i = 0, release_done_i = 0, block_in_i = 0;
  logic force_enable_i = 0, force_block_sw_i = 0, vt_setup_bad_i = 0;
  logic char_setup_bad_i = 0, logical_node_mode_allowed_i = 0;
  logic [2:0] logical_node_mode_i = 3'h1, setting_group_used_i = 3'h3;
  logic [1:0] event_sel_i = `PSB_SEL_BOTH;
  logic [15:0] imp_r_i = 16'h1234, imp_x_i = 16'h0042;
  logic [15:0] blinder_time_i = 16'h0000;
  logic [3:0] hist_idx_i = 4'h0;
  wire start_o, trip_o, blocked_o, display_event_o, ev_valid_o;
  wire [2:0] behaviour_o, ev_code_o;
  wire [1:0] condition_o, config_status_o;
  wire [15:0] ev_imp_r_o, last_r, ev_imp_x_o, ev_blinder_time_o;
  wire [15:0] last_x, last_bt;
  wire [31:0] ev_time_o, start_t, trip_t;
  wire [53:0] hist_rec_o;
  wire [3:0] hist_count_o;
  int bad_count = 0, cmp_count = 0, on_n, off_n, i, n0, n1;
  always #5 clk_i = ~clk_i;
  psb_logger #(.TICK_CYC(10)) dut (.clk_i, .sys_rst_i, .cycle_start_i,
    .pickup_i, .trip_req_i, .release_done_i, .block_in_i,
    .force_enable_i, .force_block_sw_i, .logical_node_mode_allowed_i,
    .logical_node_mode_i, .vt_setup_bad_i, .char_setup_bad_i,
    .event_sel_i, .imp_r_i, .imp_x_i, .blinder_time_i,
    .setting_group_used_i, .hist_idx_i, .start_o, .trip_o, .blocked_o,
    .behaviour_o, .condition_o, .config_status_o, .display_event_o,
    .ev_valid_o, .ev_code_o, .ev_time_o, .ev_imp_r_o, .ev_imp_x_o,
    .ev_blinder_time_o, .hist_rec_o, .hist_count_o);
  psb_evbuf_model evb (.clk_i, .ev_valid_i(ev_valid_o),
    .ev_code_i(ev_code_o), .ev_time_i(ev_time_o), .ev_imp_r_i(ev_imp_r_o),
    .ev_imp_x_i(ev_imp_x_o), .ev_bt_i(ev_blinder_time_o), .on_n_o(on_n),
    .off_n_o(off_n), .last_r_o(last_r), .last_x_o(last_x),
    .last_bt_o(last_bt), .start_t_o(start_t), .trip_t_o(trip_t));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task strobe(input logic p, b);
    @(posedge clk_i);
    cycle_start_i <= 1;
    pickup_i <= p;
    block_in_i <= b;
    @(posedge clk_i);
    cycle_start_i <= 0;
    repeat (6) @(posedge clk_i);
  endtask
  task rd(input logic [3:0] k);
    @(posedge clk_i);
    hist_idx_i <= k;
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 0;
    strobe(1, 0);
    chk("start", 1, start_o);
    chk("cond", `PSB_COND_START, condition_o);
    chk("hist", 1, hist_count_o);
    @(posedge clk_i);
    block_in_i <= 1;
    repeat (4) @(posedge clk_i);
    chk("start", 1, start_o);
    $display("test sampling done");
    strobe(1, 1);
    chk("start", 0, start_o);
    chk("blocked", 1, blocked_o);
    chk("on_n", 2, on_n);
    chk("off_n", 1, off_n);
    chk("imp", imp_r_i, last_r);
    chk("imp_x", imp_x_i, last_x);
    rd(1);
    chk("code", `PSB_EV_BLOCKED_ON, hist_rec_o[21:19]);
    chk("sg", setting_group_used_i, hist_rec_o[18:16]);
    strobe(0, 0);
    chk("blocked", 0, blocked_o);
    chk("hist", 2, hist_count_o);
    $display("test blocking done");
    trip_req_i <= 1;
    strobe(1, 0);
    strobe(1, 0);
    chk("trip", 1, trip_o);
    chk("cond", `PSB_COND_TRIP, condition_o);
    chk("same_ts", start_t, trip_t);
    trip_req_i <= 0;
    release_done_i <= 1;
    strobe(0, 0);
    chk("start", 0, start_o);
    release_done_i <= 0;
    $display("test trip done");
    event_sel_i <= `PSB_SEL_OFF;
    n0 = on_n;
    n1 = off_n;
    for (i = 0; i < 14; i++) begin
      blinder_time_i <= 16'(i);
      strobe(1, 1);
      strobe(0, 0);
    end
    chk("on_n", n0, on_n);
    chk("off_n", n1 + 14, off_n);
    chk("bt", 13, last_bt);
    chk("hist", 12, hist_count_o);
    rd(0);
    chk("oldest", 2, hist_rec_o[15:0]);
    $display("test history done");
    event_sel_i <= `PSB_SEL_ON;
    n0 = on_n;
    n1 = off_n;
    force_enable_i <= 1;
    force_block_sw_i <= 1;
    strobe(1, 0);
    chk("forced", 1, blocked_o);
    force_enable_i <= 0;
    strobe(0, 0);
    chk("on_n", n0 + 1, on_n);
    chk("off_n", n1, off_n);
    $display("test forcing done");
    event_sel_i <= `PSB_SEL_BOTH;
    logical_node_mode_allowed_i <= 1;
    for (i = 1; i < 6; i++) begin
      logical_node_mode_i <= 3'(i);
      vt_setup_bad_i <= (i == 1);
      char_setup_bad_i <= (i < 3);
      strobe(0, 0);
      chk("mode", i, behaviour_o);
      chk("cfg", i == 1 ? 1 : i == 2 ? 2 : 0, config_status_o);
    end
    logical_node_mode_allowed_i <= 0;
    strobe(0, 0);
    chk("mode", 0, behaviour_o);
    $display("test status done");
    tally_and_finish;
  end
endmodule
